// ### common/coc_pkg.sv
// Constants and types for the control output conditioner
// Overview of operation
// - Heat and cool periods 0.5 to 1000.0 s.
// - On time equals level times period.
// - High/low clamp pair per PID group.
// - Reset mode preset output is never clamped.
// - Limit ranges, narrower in heat/cool control.
// - Separate cooling clamps applied to cooling output.
// - Low at or above high: high minus one.
// - Switch selects clamping in manual mode.
// - Heat/cool manual output always clamped.
// - Manual to auto steps to violated limit.
// - Optional rate limit 0.1 to 100.0%/s.
// - No rate limit in manual, reset, fault.
// - Heat/cool: rate limit before the split.
// - On/off control ignores rate limit.
// - Manual at tight-shut low gives zero current, not in heat/cool control.
// - Auto mode never tight shuts, clamps low.
// - On/off drives output from sign of deviation.
// - One-point band; heat/cool uses two bands.
// - Two-point bands, not in heat/cool control.
`default_nettype none
package coc_pkg;
   localparam int PCT_W = 12;
   localparam int PER_W = 14;
   localparam int PV_W  = 16;
   localparam int CNT_W = 24;
   // Timing: one tick is 0.1 s
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_PERIOD_NS  = 100000000;
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_HPER   = 8'h04;
   localparam logic [7:0] OFS_CPER   = 8'h08;
   localparam logic [7:0] OFS_RATE   = 8'h0C;
   localparam logic [7:0] OFS_MANV   = 8'h10;
   localparam logic [7:0] OFS_PRESET = 8'h14;
   localparam logic [7:0] OFS_BAND1  = 8'h18;
   localparam logic [7:0] OFS_BAND2  = 8'h1C;
   localparam logic [7:0] OFS_CLIM   = 8'h20;
   localparam logic [7:0] OFS_STAT   = 8'h24;
   localparam logic [7:0] OFS_LEVEL  = 8'h28;
   localparam logic [2:0] GRP_PAGE   = 3'h2;
   // Field positions
   localparam int CTRL_HC    = 0;
   localparam int CTRL_ONOFF = 1;
   localparam int CTRL_TWOPT = 2;
   localparam int CTRL_CLMAN = 3;
   localparam int CTRL_MODE  = 4;
   localparam int CTRL_GRP   = 8;
   localparam int LIM_HI     = 0;
   localparam int LIM_LO     = 16;
   localparam int LIM_SHUT   = 31;
   localparam int HALF_HI    = 16;
   // Reset values
   localparam logic [PER_W-1:0] PER_RST  = 14'h012C;
   localparam logic [PCT_W-1:0] HI_RST   = 12'h3E8;
   localparam logic [PCT_W-1:0] LO_RST   = 12'h000;
   // Ranges, 0.1 % and 0.1 s units
   localparam logic [PER_W-1:0] PER_MIN  = 14'h0005;
   localparam logic [PER_W-1:0] PER_MAX  = 14'h2710;
   localparam logic [9:0]       RATE_MAX = 10'h3E8;
   localparam logic signed [PCT_W-1:0] HI_MAX    = 12'sh41A;
   localparam logic signed [PCT_W-1:0] HI_MIN    = -12'sh031;
   localparam logic signed [PCT_W-1:0] LO_MAX    = 12'sh419;
   localparam logic signed [PCT_W-1:0] LO_MIN    = -12'sh032;
   localparam logic signed [PCT_W-1:0] HC_HI_MIN = 12'sh001;
   localparam logic signed [PCT_W-1:0] HC_LO_MIN = 12'sh000;
   localparam logic signed [PCT_W-1:0] PCT_FULL  = 12'sh3E8;
   localparam logic signed [PCT_W-1:0] PCT_HALF  = 12'sh1F4;
   localparam logic signed [15:0]      RATE_SCALE = 16'sh000A;

   typedef enum logic [1:0] {
      MODE_AUTO  = 2'b00,
      MODE_MAN   = 2'b01,
      MODE_RESET = 2'b10
   } coc_mode_e;

   typedef struct packed {
      logic                    heatPulse;
      logic                    coolPulse;
      logic                    tightShut;
      logic signed [PCT_W-1:0] heatLevel;
      logic signed [PCT_W-1:0] coolLevel;
   } coc_out_s;
endpackage
`default_nettype wire

// ### hw/coc_output_conditioner.sv
// Control output conditioner with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module coc_output_conditioner
#(
   parameter int unsigned TICK_CYCLES = coc_pkg::TICK_CYCLES_DEF
)
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic [7:0]                  avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [31:0]                 avs_writedata,
   output logic      [31:0]                 avs_readdata,
   output logic                             avs_waitrequest,
   input  wire logic signed [coc_pkg::PCT_W-1:0] ctrlResult,
   input  wire logic signed [coc_pkg::PV_W-1:0]  processValue,
   input  wire logic signed [coc_pkg::PV_W-1:0]  setpointValue,
   input  wire logic                        inputFault,
   output coc_pkg::coc_out_s                condOut
);
   localparam int PW = coc_pkg::PCT_W;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic signed [PW-1:0] sat(
      input logic signed [PW-1:0] v,
      input logic signed [PW-1:0] lo,
      input logic signed [PW-1:0] hi);
      if (v < lo)
         return lo;
      else if (v > hi)
         return hi;
      return v;
   endfunction

   // Clamp with low forced below high when misconfigured
   function automatic logic signed [PW-1:0] clampPair(
      input logic signed [PW-1:0] v,
      input logic signed [PW-1:0] hi,
      input logic signed [PW-1:0] lo);
      logic signed [PW-1:0] loEff;
      loEff = (lo >= hi) ? hi - 12'sh001 : lo;
      return sat(v, loEff, hi);
   endfunction

   function automatic logic [coc_pkg::PER_W-1:0] satPer(
      input logic [31:0] v);
      if (v < 32'(coc_pkg::PER_MIN))
         return coc_pkg::PER_MIN;
      else if (v > 32'(coc_pkg::PER_MAX))
         return coc_pkg::PER_MAX;
      return v[coc_pkg::PER_W-1:0];
   endfunction

   // High while the period count is inside the on time
   function automatic logic onTime(
      input logic signed [PW-1:0]           level,
      input logic [coc_pkg::PER_W-1:0]      period,
      input logic [coc_pkg::PER_W-1:0]      count);
      logic [25:0] elapsed;
      logic [25:0] target;
      elapsed = 26'(count) * 26'd1000;
      target  = 26'(level[PW-2:0]) * 26'(period);
      if (level <= 12'sh000)
         return 1'b0;
      else if (level >= coc_pkg::PCT_FULL)
         return 1'b1;
      return elapsed < target;
   endfunction

   function automatic logic signed [15:0] scale10(
      input logic signed [PW-1:0] v);
      logic signed [15:0] w;
      w = 16'(v);
      return w * coc_pkg::RATE_SCALE;
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic                           hcMode_r;
   logic                           onOffMode_r;
   logic                           twoPoint_r;
   logic                           clampInManualSwitch_r;
   coc_pkg::coc_mode_e             mode_r;
   coc_pkg::coc_mode_e             modeWr;
   logic [2:0]                     group_r;
   logic [coc_pkg::PER_W-1:0]      heatPeriodSetting_r;
   logic [coc_pkg::PER_W-1:0]      coolPeriodSetting_r;
   logic [9:0]                     rateLimitSetting_r;
   logic signed [PW-1:0]           manualValue_r;
   logic signed [PW-1:0]           presetValue_r;
   logic [15:0]                    singleBandWidth_r;
   logic [15:0]                    coolBandWidth_r;
   logic [15:0]                    upperBandWidth_r;
   logic [15:0]                    lowerBandWidth_r;
   logic signed [PW-1:0]           outputHighClamp_r [8];
   logic signed [PW-1:0]           outputLowClamp_r [8];
   logic [7:0]                     tightShutCode_r;
   logic signed [PW-1:0]           coolHighClamp_r;
   logic signed [PW-1:0]           coolLowClamp_r;
   logic                           ack_r;
   logic [31:0]                    rdData_r;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire logic        busReq   = avs_read | avs_write;
   wire logic        doWrite  = avs_write & ack_r;
   wire logic        grpHit   = avs_address[7:5] == coc_pkg::GRP_PAGE;
   wire logic [2:0]  grpIdx   = avs_address[4:2];
   wire logic signed [PW-1:0] wrLo  = avs_writedata[PW-1:0];
   wire logic signed [PW-1:0] wrHi  =
      avs_writedata[coc_pkg::HALF_HI +: PW];
   wire logic [9:0]  rateWr   = (avs_writedata[9:0] > coc_pkg::RATE_MAX)
                                ? coc_pkg::RATE_MAX : avs_writedata[9:0];
   wire logic [1:0]  modeBits = avs_writedata[coc_pkg::CTRL_MODE +: 2];
   assign modeWr = (modeBits == 2'b11) ? coc_pkg::MODE_AUTO
                                       : coc_pkg::coc_mode_e'(modeBits);

   assign avs_waitrequest = busReq & ~ack_r;
   assign avs_readdata    = rdData_r;

   // ---------------------------------------------------------------
   // Output path
   // ---------------------------------------------------------------
   logic signed [15:0]        rate_r;
   logic                      heatOn_r;
   logic                      coolOn_r;
   logic [coc_pkg::CNT_W-1:0] tickCnt_r;
   logic [coc_pkg::PER_W-1:0] heatCnt_r;
   logic [coc_pkg::PER_W-1:0] coolCnt_r;
   coc_pkg::coc_out_s         condOut_r;
   coc_pkg::coc_out_s         condOut_nxt;

   localparam int CNT_W = coc_pkg::CNT_W;
   wire logic isAuto  = mode_r == coc_pkg::MODE_AUTO;
   wire logic isMan   = mode_r == coc_pkg::MODE_MAN;
   wire logic isReset = mode_r == coc_pkg::MODE_RESET;
   wire logic tick    = tickCnt_r == CNT_W'(TICK_CYCLES - 1);

   // Combined value before any split
   wire logic signed [PW-1:0] rawValue = isReset ? presetValue_r
                                       : isMan ? manualValue_r
                                       : ctrlResult;
   wire logic signed [15:0] target10 = scale10(rawValue);
   wire logic signed [15:0] rateStep = 16'(rateLimitSetting_r);
   wire logic rateBypass = ~isAuto | inputFault | onOffMode_r
                           | (rateLimitSetting_r == 10'h000)
                           | onOffMode_r;
   wire logic signed [15:0] delta  = target10 - rate_r;
   wire logic signed [15:0] rate_nxt =
      rateBypass         ? target10 :
      ~tick              ? rate_r :
      (delta > rateStep) ? rate_r + rateStep :
      (delta < -rateStep)? rate_r - rateStep : target10;
   // Rate limit acts on the combined value
   wire logic signed [PW-1:0] combined =
      PW'(rate_r / coc_pkg::RATE_SCALE);

   // Split into heating and cooling sides
   wire logic signed [PW-1:0] splitHeat = (combined > coc_pkg::PCT_HALF)
      ? PW'((combined - coc_pkg::PCT_HALF) <<< 1) : 12'sh000;
   wire logic signed [PW-1:0] splitCool = (combined < coc_pkg::PCT_HALF)
      ? PW'((coc_pkg::PCT_HALF - combined) <<< 1) : 12'sh000;
   wire logic signed [PW-1:0] heatRaw = hcMode_r ? splitHeat : combined;

   // Limits of the selected group, narrowed in heat/cool control
   wire logic signed [PW-1:0] grpHi = outputHighClamp_r[group_r];
   wire logic signed [PW-1:0] grpLo = outputLowClamp_r[group_r];
   wire logic signed [PW-1:0] hiEff = hcMode_r
      ? sat(grpHi, coc_pkg::HC_HI_MIN, coc_pkg::HI_MAX) : grpHi;
   wire logic signed [PW-1:0] loEff = hcMode_r
      ? sat(grpLo, coc_pkg::HC_LO_MIN, coc_pkg::LO_MAX) : grpLo;
   // Clamp in auto; in manual per switch, always in heat/cool; never in reset
   wire logic applyClamp = isAuto
      | (isMan & (clampInManualSwitch_r | hcMode_r));
   // Auto always clamps, so a manual-to-auto swap jumps to the limit
   wire logic signed [PW-1:0] heatLevel = applyClamp
      ? clampPair(heatRaw, hiEff, loEff) : heatRaw;
   wire logic signed [PW-1:0] coolLevel = applyClamp
      ? clampPair(splitCool, coolHighClamp_r, coolLowClamp_r)
      : splitCool;
   wire logic tightShut = isMan & ~hcMode_r & tightShutCode_r[group_r]
                          & (manualValue_r <= loEff);

   // On/off decision from deviation
   wire logic signed [16:0] dev = 17'(processValue) - 17'(setpointValue);
   wire logic signed [16:0] lowTrip = twoPoint_r & ~hcMode_r
      ? -17'(lowerBandWidth_r) : -17'(singleBandWidth_r);
   wire logic signed [16:0] highTrip = twoPoint_r & ~hcMode_r
      ? 17'(upperBandWidth_r) : 17'sh00000;
   wire logic heatOn_nxt = (dev < lowTrip) ? 1'b1
                         : (dev > highTrip) ? 1'b0
                         : (dev == 17'sh00000 && !(twoPoint_r & ~hcMode_r))
                           ? 1'b0 : heatOn_r;
   wire logic coolOn_nxt = ~hcMode_r ? 1'b0
                         : (dev > 17'(coolBandWidth_r)) ? 1'b1
                         : (dev <= 17'sh00000) ? 1'b0 : coolOn_r;

   // Period counters on the 0.1 s tick
   wire logic heatWrap = heatCnt_r >= heatPeriodSetting_r - 14'h0001;
   wire logic coolWrap = coolCnt_r >= coolPeriodSetting_r - 14'h0001;
   wire logic onOffAuto = onOffMode_r & isAuto;

   assign condOut_nxt.heatPulse = onOffAuto ? heatOn_r
      : ~tightShut & onTime(heatLevel, heatPeriodSetting_r, heatCnt_r);
   assign condOut_nxt.coolPulse = hcMode_r & (onOffAuto ? coolOn_r
      : onTime(coolLevel, coolPeriodSetting_r, coolCnt_r));
   assign condOut_nxt.tightShut = tightShut;
   assign condOut_nxt.heatLevel = heatLevel;
   assign condOut_nxt.coolLevel = hcMode_r ? coolLevel : 12'sh000;
   assign condOut = condOut_r;

   // Read mux
   wire logic [31:0] rdCtrl = {21'h0, group_r, 2'h0, mode_r,
      clampInManualSwitch_r, twoPoint_r, onOffMode_r, hcMode_r};
   wire logic [31:0] rdMux =
      grpHit ? {tightShutCode_r[grpIdx], 3'h0,
                outputLowClamp_r[grpIdx], 4'h0,
                outputHighClamp_r[grpIdx]} :
      (avs_address == coc_pkg::OFS_CTRL)   ? rdCtrl :
      (avs_address == coc_pkg::OFS_HPER)   ? 32'(heatPeriodSetting_r) :
      (avs_address == coc_pkg::OFS_CPER)   ? 32'(coolPeriodSetting_r) :
      (avs_address == coc_pkg::OFS_RATE)   ? 32'(rateLimitSetting_r) :
      (avs_address == coc_pkg::OFS_MANV)   ? 32'(manualValue_r) :
      (avs_address == coc_pkg::OFS_PRESET) ? 32'(presetValue_r) :
      (avs_address == coc_pkg::OFS_BAND1)
         ? {coolBandWidth_r, singleBandWidth_r} :
      (avs_address == coc_pkg::OFS_BAND2)
         ? {lowerBandWidth_r, upperBandWidth_r} :
      (avs_address == coc_pkg::OFS_CLIM)
         ? {4'h0, coolLowClamp_r, 4'h0, coolHighClamp_r} :
      (avs_address == coc_pkg::OFS_STAT)
         ? {28'h0, coolOn_r, condOut_r.tightShut,
            condOut_r.coolPulse, condOut_r.heatPulse} :
      (avs_address == coc_pkg::OFS_LEVEL)
         ? {4'h0, condOut_r.coolLevel, 4'h0, condOut_r.heatLevel} :
      32'h0000_0000;

   // ---------------------------------------------------------------
   // Bus handshake and configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ack_r    <= 1'b0;
         rdData_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= busReq & ~ack_r;
         if (avs_read & ~ack_r)
            rdData_r <= rdMux;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hcMode_r              <= 1'b0;
         onOffMode_r           <= 1'b0;
         twoPoint_r            <= 1'b0;
         clampInManualSwitch_r <= 1'b0;
         mode_r                <= coc_pkg::MODE_AUTO;
         group_r               <= 3'h0;
         heatPeriodSetting_r   <= coc_pkg::PER_RST;
         coolPeriodSetting_r   <= coc_pkg::PER_RST;
         rateLimitSetting_r    <= 10'h000;
         manualValue_r         <= coc_pkg::LO_RST;
         presetValue_r         <= coc_pkg::LO_RST;
         singleBandWidth_r     <= 16'h0000;
         coolBandWidth_r       <= 16'h0000;
         upperBandWidth_r      <= 16'h0000;
         lowerBandWidth_r      <= 16'h0000;
         tightShutCode_r       <= 8'h00;
         coolHighClamp_r       <= coc_pkg::HI_RST;
         coolLowClamp_r        <= coc_pkg::LO_RST;
         for (int i = 0; i < 8; i++)
         begin
            outputHighClamp_r[i] <= coc_pkg::HI_RST;
            outputLowClamp_r[i]  <= coc_pkg::LO_RST;
         end
      end
      else if (doWrite)
      begin
         if (grpHit)
         begin
            outputHighClamp_r[grpIdx] <=
               sat(wrLo, coc_pkg::HI_MIN, coc_pkg::HI_MAX);
            outputLowClamp_r[grpIdx]  <=
               sat(wrHi, coc_pkg::LO_MIN, coc_pkg::LO_MAX);
            tightShutCode_r[grpIdx] <= avs_writedata[coc_pkg::LIM_SHUT];
         end
         case (avs_address)
            coc_pkg::OFS_CTRL:
            begin
               hcMode_r              <= avs_writedata[coc_pkg::CTRL_HC];
               onOffMode_r           <= avs_writedata[coc_pkg::CTRL_ONOFF];
               twoPoint_r            <= avs_writedata[coc_pkg::CTRL_TWOPT];
               clampInManualSwitch_r <= avs_writedata[coc_pkg::CTRL_CLMAN];
               mode_r                <= modeWr;
               group_r               <= avs_writedata[coc_pkg::CTRL_GRP +: 3];
            end
            coc_pkg::OFS_HPER:   heatPeriodSetting_r <= satPer(avs_writedata);
            coc_pkg::OFS_CPER:   coolPeriodSetting_r <= satPer(avs_writedata);
            coc_pkg::OFS_RATE:   rateLimitSetting_r  <= rateWr;
            coc_pkg::OFS_MANV:   manualValue_r <= wrLo;
            coc_pkg::OFS_PRESET: presetValue_r <= wrLo;
            coc_pkg::OFS_BAND1:
            begin
               singleBandWidth_r <= avs_writedata[15:0];
               coolBandWidth_r   <= avs_writedata[31:16];
            end
            coc_pkg::OFS_BAND2:
            begin
               upperBandWidth_r <= avs_writedata[15:0];
               lowerBandWidth_r <= avs_writedata[31:16];
            end
            coc_pkg::OFS_CLIM:
            begin
               coolHighClamp_r <=
                  sat(wrLo, coc_pkg::HC_HI_MIN, coc_pkg::HI_MAX);
               coolLowClamp_r  <=
                  sat(wrHi, coc_pkg::HC_LO_MIN, coc_pkg::LO_MAX);
            end
            default:
            begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Timebase, rate limiter, on/off state and output register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tickCnt_r  <= '0;
         heatCnt_r  <= '0;
         coolCnt_r  <= '0;
         rate_r     <= 16'sh0000;
         heatOn_r   <= 1'b0;
         coolOn_r   <= 1'b0;
         condOut_r  <= '0;
      end
      else
      begin
         tickCnt_r <= tick ? '0 : tickCnt_r + 24'h000001;
         if (tick)
         begin
            heatCnt_r <= heatWrap ? '0 : heatCnt_r + 14'h0001;
            coolCnt_r <= coolWrap ? '0 : coolCnt_r + 14'h0001;
         end
         rate_r     <= rate_nxt;
         heatOn_r   <= heatOn_nxt;
         coolOn_r   <= coolOn_nxt;
         condOut_r  <= condOut_nxt;
      end
   end
endmodule // coc_output_conditioner
`default_nettype wire

// ### verif/coc_output_conditioner_sva.sv
// Port assertions for the output conditioner
`timescale 1ns/1ps
`default_nettype none
module coc_output_conditioner_sva
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire coc_pkg::coc_out_s condOut
);
   // ---------------------------------
   // Bus and output checks
   // ---------------------------------
   wire logic req;
   assign req = avs_read || avs_write;
   sequence sWait;
      req && avs_waitrequest;
   endsequence
   sequence sAck;
      req && !avs_waitrequest;
   endsequence
   chk_idle_no_wait: assert property (@(posedge clk) disable iff (!rst_n)
      !req |-> !avs_waitrequest) else $error("wait while idle");
   chk_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
      sWait |=> sAck) else $error("wait not exactly one cycle");
   chk_ack_then_new: assert property (@(posedge clk) disable iff (!rst_n)
      sAck |=> !req || avs_waitrequest) else $error("no wait on new req");
   chk_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !avs_read |=> $stable(avs_readdata)) else $error("readdata moved");
   chk_reset_out: assert property (@(posedge clk) disable iff (1'b0)
      !rst_n |=> condOut == '0) else $error("outputs not cleared");
   chk_reset_rdata: assert property (@(posedge clk) disable iff (1'b0)
      !rst_n |=> avs_readdata == 32'h00000000) else $error("rdata not 0");
   chk_shut_heat: assert property (@(posedge clk) disable iff (!rst_n)
      condOut.tightShut |-> !condOut.heatPulse) else $error("pulse in shut");
   chk_shut_cool: assert property (@(posedge clk) disable iff (!rst_n)
      condOut.tightShut |-> !condOut.coolPulse) else $error("cool in shut");
endmodule // coc_output_conditioner_sva
bind coc_output_conditioner coc_output_conditioner_sva
   coc_output_conditioner_sva_inst (.clk(clk), .rst_n(rst_n),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .condOut(condOut));
`default_nettype wire

// ### verif/coc_stage_model.sv
// Output stage model: current loop and pulse on-time meter
`timescale 1ns/1ps
`default_nettype none
module coc_stage_model
(
   input  wire logic              clk,
   input  wire logic              clr,
   input  wire coc_pkg::coc_out_s condOut,
   output logic      [15:0]       onCycles,
   output logic      [15:0]       currentUa
);
   // 4-20 mA loop, 16 uA per 0.1 %
   assign currentUa = condOut.tightShut ? 16'h0000
      : 16'(32'sh0FA0 + 32'(condOut.heatLevel) * 32'sh10);
   always_ff @(posedge clk)
   begin
      if (clr)
         onCycles <= 16'h0000;
      else if (condOut.heatPulse)
         onCycles <= onCycles + 16'h0001;
   end
endmodule // coc_stage_model
`default_nettype wire

// ### verif/coc_output_conditioner_tb_top.sv
// Self-checking bench for the output conditioner
`timescale 1ns/1ps
`default_nettype none
module coc_output_conditioner_tb_top;
   logic               clk = 1'b0;
   logic               rstN = 1'b0;
   logic [7:0]         addr = 8'h00;
   logic               rd = 1'b0;
   logic               wr = 1'b0;
   logic [31:0]        wdata = 32'h00000000;
   logic [31:0]        rdata;
   logic               waitReq;
   logic signed [11:0] ctrlRes = 12'h000;
   logic signed [15:0] pv = 16'h0000;
   logic signed [15:0] sp = 16'h0100;
   logic               fault = 1'b0;
   logic               clr = 1'b0;
   coc_pkg::coc_out_s  condOut;
   logic [15:0]        onCycles;
   logic [15:0]        currentUa;
   logic [31:0]        got;
   int                 fail_count = 0;
   int                 num_checks = 0;
   int                 cycles = 0;
   logic signed [11:0] lvlTab [2] = '{12'h190, 12'h3E8};
   logic [15:0]        onTab [2] = '{16'h0028, 16'h0064};
   logic signed [15:0] pvTab [4] = '{16'h010A, 16'h00FD, 16'h00F6, 16'h00FD};
   logic               hpTab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   always #5 clk = ~clk;
   coc_output_conditioner #(.TICK_CYCLES(2)) coc_output_conditioner_inst
      (.clk(clk), .rst_n(rstN), .avs_address(addr), .avs_read(rd),
       .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
       .avs_waitrequest(waitReq), .ctrlResult(ctrlRes),
       .processValue(pv), .setpointValue(sp), .inputFault(fault),
       .condOut(condOut));
   coc_stage_model coc_stage_model_inst (.clk(clk), .clr(clr),
      .condOut(condOut), .onCycles(onCycles), .currentUa(currentUa));
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmpWord(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic busAcc(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      do
      begin
         @(posedge clk);
      end while (waitReq !== 1'b0);
      got = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      busAcc(1'b1, a, d);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      busAcc(1'b0, a, 32'h00000000);
      cmpWord(got, e);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic cmpLvl(input logic [11:0] g, input logic [11:0] e);
      cmpWord({20'h00000, g}, {20'h00000, e});
   endtask
   task automatic lvlAfter(input logic [11:0] r, input logic [11:0] e);
      @(posedge clk);
      ctrlRes <= r;
      settle(4);
      cmpLvl(condOut.heatLevel, e);
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         $display("MISMATCH t=%0t timeout", $time);
         summarize();
      end
   end
   // ---------------------------------
   // Tests
   // ---------------------------------
   initial
   begin
      repeat (2) @(posedge clk);
      rstN <= 1'b1;
      rdChk(8'h04, 32'h0000012C);
      rdChk(8'h40, 32'h000003E8);
      wrReg(8'h04, 32'h00000001);
      rdChk(8'h04, 32'h00000005);
      wrReg(8'h04, 32'h00004E20);
      rdChk(8'h04, 32'h00002710);
      rdChk(8'hFC, 32'h00000000);
      $display("test registers done");
      wrReg(8'h04, 32'h00000005);
      for (int i = 0; i < 2; i++)
      begin
         lvlAfter(lvlTab[i], lvlTab[i]);
         settle(30);
         @(posedge clk) clr <= 1'b1;
         @(posedge clk) clr <= 1'b0;
         settle(100);
         cmpWord({16'h0000, onCycles}, {16'h0000, onTab[i]});
      end
      $display("test pulse done");
      wrReg(8'h48, 32'h00640258);
      wrReg(8'h00, 32'h00000200);
      lvlAfter(12'h384, 12'h258);
      lvlAfter(12'h032, 12'h064);
      wrReg(8'h48, 32'h02BC0258);
      lvlAfter(12'h000, 12'h257);
      wrReg(8'h48, 32'h00640258);
      wrReg(8'h14, 32'h00000384);
      wrReg(8'h00, 32'h00000220);
      lvlAfter(12'h000, 12'h384);
      $display("test clamp done");
      wrReg(8'h0C, 32'h0000000A);
      wrReg(8'h10, 32'h00000384);
      wrReg(8'h00, 32'h00000210);
      lvlAfter(12'h000, 12'h384);
      wrReg(8'h00, 32'h00000218);
      lvlAfter(12'h384, 12'h258);
      wrReg(8'h00, 32'h00000210);
      lvlAfter(12'h384, 12'h384);
      wrReg(8'h00, 32'h00000200);
      settle(3);
      cmpLvl(condOut.heatLevel, 12'h258);
      // Ramp from 90 % must first pass the 60 % clamp
      @(posedge clk) ctrlRes <= 12'h000;
      settle(640);
      cmpWord({31'h0, condOut.heatLevel > 12'sh226
         && condOut.heatLevel < 12'sh258}, 32'h00000001);
      @(posedge clk) fault <= 1'b1;
      settle(4);
      cmpLvl(condOut.heatLevel, 12'h064);
      @(posedge clk) fault <= 1'b0;
      $display("test rate done");
      wrReg(8'h0C, 32'h00000000);
      wrReg(8'h48, 32'h80640258);
      wrReg(8'h10, 32'h00000032);
      wrReg(8'h00, 32'h00000210);
      settle(4);
      cmpWord({15'h0, condOut.tightShut, currentUa}, 32'h00010000);
      wrReg(8'h00, 32'h00000200);
      lvlAfter(12'h000, 12'h064);
      cmpWord({31'h0, condOut.tightShut}, 32'h00000000);
      $display("test shut done");
      wrReg(8'h0C, 32'h0000000A);
      wrReg(8'h18, 32'h00000005);
      wrReg(8'h00, 32'h00000202);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk) pv <= pvTab[i];
         settle(3);
         cmpWord({31'h0, condOut.heatPulse}, {31'h0, hpTab[i]});
      end
      $display("test onoff done");
      wrReg(8'h0C, 32'h00000000);
      wrReg(8'h20, 32'h0000012C);
      wrReg(8'h00, 32'h00000001);
      lvlAfter(12'h064, 12'h000);
      cmpLvl(condOut.coolLevel, 12'h12C);
      $display("test heatcool done");
      summarize();
   end
endmodule // coc_output_conditioner_tb_top
`default_nettype wire
